// ### scps_host_model.sv
`timescale 1ns/1ps
module scps_host_model
#(
    parameter int P_WAKE_CYC = 20
)
(
    input  wire logic i_clk,
    output logic      o_start,
    output logic      o_sck
);
    initial
    begin
        o_start = 1'b0;
        o_sck   = 1'b0;
    end

    // Start edge; pin drops 30 ns later, after the conversion has begun
    task automatic start_pulse;
        o_start = 1'b1;
        repeat (3) @(negedge i_clk);
        o_start = 1'b0;
    endtask : start_pulse

    // One 125 ns serial-clock period; clock rests low outside frames
    task automatic sck_pulse;
        o_sck = 1'b1;
        #62.5;
        o_sck = 1'b0;
        #62.5;
    endtask : sck_pulse

    // Wake settle time before the next start
    task automatic wake_wait;
        repeat (P_WAKE_CYC) @(negedge i_clk);
    endtask : wake_wait
endmodule : scps_host_model

// ### scps_map.svh
// Notes on behaviour
// - A start-pin rising edge in nap begins a conversion and powers the converter core.
// - Start edges during a conversion are ignored; a conversion never restarts.
// - Busy stays high for the whole conversion and drops when it completes.
// - Acquisition of the next sample begins 527 ns after a conversion start; the code begins it 530 ns (53 cycles) in.
// - Conversion is timed internally and lasts at most 1.5 us.
// - After a conversion with no sleep request the block naps until the next start edge.
// - Nap powers down only the core; serial path and the rest stay on.
// - The last result stays readable for shifting out during nap.
// - Two start toggles with no serial-clock rise between them request sleep.
// - Sleep begins when busy falls on the last conversion started.
// - A serial-clock rising edge wakes the block from sleep.
// - Reset at power-up or supply drop; re-initialise when supply returns.
// - Each result is a 16-bit two's complement value.
`ifndef SCPS_MAP_SVH
`define SCPS_MAP_SVH

`define SCPS_CLK_NS        10
`define SCPS_CONV_MAX_NS   1500
`define SCPS_ACQ_START_NS  527
`define SCPS_ACQ_WIN_NS    1460
`define SCPS_SETTLE_NS     200000
`define SCPS_RESULT_W      16
`define SCPS_RESULT_RST    16'h0000
`define SCPS_SLEEP_TOGGLES 2'h2
`define SCPS_CONV_CYC      (`SCPS_CONV_MAX_NS / `SCPS_CLK_NS)
`define SCPS_ACQ_CYC       ((`SCPS_ACQ_START_NS + `SCPS_CLK_NS - 1) / `SCPS_CLK_NS)
`define SCPS_SETTLE_CYC    ((`SCPS_SETTLE_NS + `SCPS_CLK_NS - 1) / `SCPS_CLK_NS)

`endif

// ### scps_pkg.sv
package scps_pkg;

    typedef enum logic [3:0]
    {
        ST_SETTLE = 4'h1,
        ST_NAP    = 4'h2,
        ST_CONV   = 4'h4,
        ST_SLEEP  = 4'h8
    } scps_state_t;

endpackage : scps_pkg

// ### scps_sync.sv
`timescale 1ns/1ps
module scps_sync
(
    input  wire logic i_clk,
    input  wire logic i_srst,
    input  wire logic i_pin,
    output logic      o_level,
    output logic      o_rise
);

    logic meta_r;
    logic sync_r;
    logic prev_r;

    // Two flops before use, third for edge finding
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
        end
        else
        begin
            meta_r <= i_pin;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign o_level = sync_r;
    assign o_rise  = sync_r & ~prev_r;

endmodule : scps_sync

// ### scps_top.sv
`timescale 1ns/1ps
`include "scps_map.svh"
module scps_top
#(
    parameter int P_SETTLE_CYC = `SCPS_SETTLE_CYC,
    parameter int P_RESULT_W   = `SCPS_RESULT_W
)
(
    input  wire logic                  i_clk,
    input  wire logic                  i_srst,
    input  wire logic                  i_conversion_start_in,
    input  wire logic                  i_sck,
    input  wire logic [P_RESULT_W-1:0] i_core_result,
    output logic                       o_busy,
    output logic                       o_core_power_on,
    output logic                       o_acquire,
    output logic                       o_napping,
    output logic                       o_asleep,
    output logic                       o_serial_path_on,
    output logic                       o_settling,
    output logic                       o_early_start,
    output logic                       o_result_new,
    output logic [P_RESULT_W-1:0]      o_result
);

    localparam int CONV_CYC = `SCPS_CONV_CYC;
    localparam int ACQ_CYC  = `SCPS_ACQ_CYC;
    localparam int SET_W    = $clog2(P_SETTLE_CYC + 1);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic start_rise;
    logic sck_rise;

    scps_sync u_start_sync
    (
        .i_clk   (i_clk),
        .i_srst  (i_srst),
        .i_pin   (i_conversion_start_in),
        .o_level (),
        .o_rise  (start_rise)
    );

    scps_sync u_sck_sync
    (
        .i_clk   (i_clk),
        .i_srst  (i_srst),
        .i_pin   (i_sck),
        .o_level (),
        .o_rise  (sck_rise)
    );

    ////////////////////////////////////////////////////////////////////////////
    // State and counters
    scps_pkg::scps_state_t state_r;
    scps_pkg::scps_state_t state_nxt;
    logic [7:0]            conv_cnt_r;
    logic [SET_W-1:0]      settle_cnt_r;
    logic [1:0]            tog_cnt_r;
    logic [1:0]            tog_cnt_nxt;
    logic                  acquire_r;
    logic                  early_r;
    logic                  result_new_r;
    logic [P_RESULT_W-1:0] result_r;

    wire in_settle  = (state_r == scps_pkg::ST_SETTLE);
    wire in_nap     = (state_r == scps_pkg::ST_NAP);
    wire in_conv    = (state_r == scps_pkg::ST_CONV);
    wire in_sleep   = (state_r == scps_pkg::ST_SLEEP);
    wire settle_end = (settle_cnt_r == SET_W'(P_SETTLE_CYC - 1));
    wire conv_done  = in_conv && (conv_cnt_r == 8'(CONV_CYC - 1));
    wire start_ok   = in_nap && start_rise;
    wire sleep_req  = (tog_cnt_r == `SCPS_SLEEP_TOGGLES);
    wire acq_hit    = in_conv && (conv_cnt_r == 8'(ACQ_CYC - 1));

    // Start edges outside settle and sleep count up to two; a serial-clock rise clears, a same-cycle such start counts one
    assign tog_cnt_nxt = sck_rise ? {1'b0, start_rise && !in_settle && !in_sleep}
                       : (start_rise && !in_settle && !in_sleep && !sleep_req) ? tog_cnt_r + 2'h1
                       : tog_cnt_r;

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            scps_pkg::ST_SETTLE:
            begin
                if (settle_end)
                    state_nxt = scps_pkg::ST_NAP;
            end
            scps_pkg::ST_NAP:
            begin
                if (start_rise)
                    state_nxt = scps_pkg::ST_CONV;
            end
            scps_pkg::ST_CONV:
            begin
                if (conv_done)
                    state_nxt = sleep_req ? scps_pkg::ST_SLEEP : scps_pkg::ST_NAP;
            end
            scps_pkg::ST_SLEEP:
            begin
                if (sck_rise)
                    state_nxt = scps_pkg::ST_NAP;
            end
            default:
            begin
                state_nxt = scps_pkg::ST_SETTLE;
            end
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            state_r      <= scps_pkg::ST_SETTLE;
            settle_cnt_r <= '0;
            tog_cnt_r    <= 2'h0;
        end
        else
        begin
            state_r      <= state_nxt;
            settle_cnt_r <= in_settle ? settle_cnt_r + SET_W'(1) : settle_cnt_r;
            tog_cnt_r    <= tog_cnt_nxt;
        end
    end

    // Conversion timer: held at zero outside conversion, start edges inside do not touch it
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            conv_cnt_r <= 8'h00;
        else if (in_conv)
            conv_cnt_r <= conv_cnt_r + 8'h01;
        else
            conv_cnt_r <= 8'h00;
    end

    // Acquisition runs from 530 ns (53 cycles) into the conversion until the next start, sleep or settle
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            acquire_r <= 1'b0;
        else if (acq_hit)
            acquire_r <= 1'b1;
        else if (start_ok || in_sleep || in_settle)
            acquire_r <= 1'b0;
    end

    // Early start flag held until the first accepted conversion
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            early_r <= 1'b0;
        else if (in_settle && start_rise)
            early_r <= 1'b1;
        else if (start_ok)
            early_r <= 1'b0;
    end

    // Result captured at completion, held through nap and sleep
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            result_r     <= P_RESULT_W'(`SCPS_RESULT_RST);
            result_new_r <= 1'b0;
        end
        else
        begin
            result_new_r <= conv_done;
            if (conv_done)
                result_r <= i_core_result;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign o_busy           = in_conv;
    assign o_core_power_on  = in_conv;
    assign o_acquire        = acquire_r;
    assign o_napping        = in_nap;
    assign o_asleep         = in_sleep;
    assign o_serial_path_on = !in_sleep;
    assign o_settling       = in_settle;
    assign o_early_start    = early_r;
    assign o_result_new     = result_new_r;
    assign o_result         = result_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    chk_start_core: assert property (start_ok |=> o_busy && o_core_power_on)
        else $error("start edge in nap did not begin conversion");
    chk_no_restart: assert property (in_conv && start_rise && !conv_done |=> conv_cnt_r == $past(conv_cnt_r) + 8'h01)
        else $error("conversion timer disturbed by start edge");
    chk_busy_hold: assert property ($rose(o_busy) |-> o_busy [*8] ##1 o_busy)
        else $error("busy dropped early");
    chk_conv_length: assert property ($fell(o_busy) |-> $past(conv_cnt_r) == 8'(CONV_CYC - 1))
        else $error("conversion length wrong");
    chk_acq_start: assert property ($rose(o_acquire) |-> o_busy && conv_cnt_r == 8'(ACQ_CYC))
        else $error("acquisition began at wrong time");
    chk_nap_after: assert property ($fell(o_busy) |-> (o_napping || o_asleep) && !o_core_power_on)
        else $error("no nap or sleep after conversion");
    chk_nap_power: assert property (o_napping |-> o_serial_path_on && !o_core_power_on)
        else $error("nap power state wrong");
    chk_result_hold: assert property (o_napping && $past(o_napping) |-> $stable(o_result))
        else $error("result changed during nap");
    chk_sleep_entry: assert property (conv_done && sleep_req |=> o_asleep)
        else $error("sleep not entered at end of busy");
    chk_sleep_count: assert property (sck_rise && !start_rise |=> tog_cnt_r == 2'h0)
        else $error("toggle count not cleared by serial clock");
    chk_wake_up: assert property (o_asleep && sck_rise |=> o_napping)
        else $error("no wake on serial clock rise");
    chk_settle_idle: assert property (o_settling && start_rise |=> !o_busy && o_early_start)
        else $error("early start not refused and flagged");

    cov_conversion: cover property (start_ok ##1 o_busy [*8]);
    cov_sleep: cover property (conv_done && sleep_req ##1 o_asleep);
    cov_wake: cover property (o_asleep && sck_rise ##1 o_napping);
    cov_early: cover property (o_settling && start_rise);

endmodule : scps_top

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic        i_clk, i_srst, start_pin, sck_pin, busy, core_on, acquire, napping;
    logic        asleep, ser_on, settling, early, res_new;
    logic [15:0] core_result, result;
    int          error_cnt, checks_done, cyc;

    scps_top #(.P_SETTLE_CYC(50), .P_RESULT_W(16)) u_dut
    (
        .i_clk(i_clk), .i_srst(i_srst), .i_conversion_start_in(start_pin), .i_sck(sck_pin),
        .i_core_result(core_result), .o_busy(busy), .o_core_power_on(core_on), .o_acquire(acquire),
        .o_napping(napping), .o_asleep(asleep), .o_serial_path_on(ser_on), .o_settling(settling),
        .o_early_start(early), .o_result_new(res_new), .o_result(result)
    );
    scps_host_model u_host (.i_clk(i_clk), .o_start(start_pin), .o_sck(sck_pin));

    initial
    begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic end_of_test;
        $display("errors=%0d checks=%0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test

    task automatic wait_busy(input logic lvl);
        int n;
        n = 0;
        while (busy !== lvl && n < 200)
        begin
            @(negedge i_clk);
            n++;
        end
        check({31'h0, busy}, {31'h0, lvl});
    endtask : wait_busy

    task automatic t_reset_settle;
        int n;
        check(32'({ser_on, settling, busy, napping, asleep, result}), 32'h00180000);
        i_srst = 1'b0;
        u_host.start_pulse();
        repeat (8) @(negedge i_clk);
        check(32'({busy, early}), 32'h1);
        n = 0;
        while (settling !== 1'b0 && n < 100)
        begin
            @(negedge i_clk);
            n++;
        end
        check(32'({settling, napping}), 32'h1);
    endtask : t_reset_settle

    task automatic t_convert;
        int n, acq_at;
        core_result = 16'h8001;
        u_host.start_pulse();
        wait_busy(1'b1);
        check(32'({core_on, napping, early}), 32'h4);
        fork
        begin
            repeat (20) @(negedge i_clk);
            u_host.sck_pulse();
            repeat (30) @(negedge i_clk);
            u_host.start_pulse();
        end
        join_none
        n = 0;
        acq_at = 0;
        while (busy === 1'b1 && n < 300)
        begin
            if (acquire === 1'b1 && acq_at == 0)
                acq_at = n;
            @(negedge i_clk);
            n++;
        end
        check(32'(n), 32'd150);
        check(32'(acq_at), 32'd53);
        check(32'({res_new, napping, core_on, ser_on, asleep}), 32'h1A);
        check({16'h0, result}, 32'h8001);
        core_result = 16'h1234;
        u_host.sck_pulse();
        repeat (4) @(negedge i_clk);
        check({14'h0, res_new, ser_on, result}, 32'h18001);
    endtask : t_convert

    task automatic t_sleep;
        u_host.start_pulse();
        wait_busy(1'b1);
        wait_busy(1'b0);
        check({31'h0, asleep}, 32'h0);
        u_host.start_pulse();
        wait_busy(1'b1);
        wait_busy(1'b0);
        check(32'({asleep, ser_on, napping}), 32'h4);
        u_host.start_pulse();
        repeat (8) @(negedge i_clk);
        check(32'({busy, asleep, acquire}), 32'h2);
        u_host.sck_pulse();
        repeat (4) @(negedge i_clk);
        check(32'({asleep, napping}), 32'h1);
        u_host.wake_wait();
        u_host.start_pulse();
        wait_busy(1'b1);
        wait_busy(1'b0);
        check(32'({asleep, napping}), 32'h1);
    endtask : t_sleep

    always @(posedge i_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            error_cnt++;
            end_of_test();
        end
    end

    initial
    begin
        i_srst = 1'b1;
        core_result = 16'h0000;
        repeat (5) @(negedge i_clk);
        t_reset_settle();
        t_convert();
        t_sleep();
        end_of_test();
    end
endmodule : tb_top
